// *** verilog/spi_cs_fmt_pkg.sv ***
/*
 * Constants of the slave-select and data-format slice of the serial
 * peripheral: register byte offsets, field positions, reset values,
 * write masks and the transfer engine states.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package spi_cs_fmt_pkg;

	// ****************************************************************
	// Register byte offsets.
	// ****************************************************************
	localparam logic [7:0] ADDR_DEFSEL   = 8'h00;
	localparam logic [7:0] ADDR_TXCTL    = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_RXDATA   = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [3:0] ADDR_FMT_PAGE = 4'h2;

	// ****************************************************************
	// Reset values and write masks.
	// ****************************************************************
	localparam logic [7:0]  DEF_SEL_RESET  = 8'hFF;
	localparam logic [31:0] FMT_RESET      = 32'h0000_0000;
	localparam logic [31:0] FMT_WMASK_PRIV = 32'h3FF7_FF1F;
	localparam logic [31:0] FMT_WMASK_USER = 32'h3F77_FF1F;
	localparam int          NUM_FMT        = 4;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int FMT_INTER_TRANSFER_DELAY_LSB = 24;
	localparam int FMT_INTER_TRANSFER_DELAY_W   = 6;
	localparam int FMT_PARITY_POLARITY_BIT = 23;
	localparam int FMT_PARITY_ENABLE_BIT = 22;
	localparam int TX_SEL_LSB     = 16;
	localparam int TX_FMT_LSB     = 24;
	localparam int TX_DREQ_BIT    = 26;
	localparam int TX_HOLD_BIT    = 28;
	localparam int IRQ_DONE_BIT   = 0;
	localparam int IRQ_PERR_BIT   = 1;

	// ****************************************************************
	// Timing: the gap adds this many module clocks to the delay field.
	// ****************************************************************
	localparam logic [6:0] GAP_EXTRA = 7'h02;

	// ****************************************************************
	// Transfer engine states, Gray coded along idle, shift, gap.
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SHIFT = 2'h1,
		ST_GAP   = 2'h3
	} state_e;

endpackage

// *** verilog/spi_cs_fmt.sv ***
/*
 * Slave-select and data-format slice of a serial peripheral, with a small
 * transfer engine, an AHB-Lite register slave and an interrupt output.
 * Assumes a free single-slave AHB-Lite bus on i_clk and a serial clock
 * that arrives on a pin from outside the clock domain, idle low.
 */
// Local design decisions: the register offsets and register access over AHB-Lite.
// What this block does
// - Idle selects follow default pattern.
// - Pattern bit i drives select output i.
// - Pattern bit 0 low, bit 1 high.
// - During transfer selects follow transfer pattern.
// - Hold bit keeps transfer selects afterwards.
// - Reserved bits read zero, ignore writes.
// - Four independent data format registers.
// - Gap only when delay request set.
// - Gap lasts delay field plus two.
// - Polarity 0 appends even parity.
// - Polarity bit written only when privileged.
// - Polarity 1 appends odd parity.
// - Parity mismatch sets parity error flag.
`timescale 1ns/1ps
module spi_cs_fmt #(
	parameter int CHAR_BITS = 8
) (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	// AHB-Lite slave.
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [3:0]  i_hprot,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// Serial link.
	input  wire logic        i_link_clk,
	input  wire logic        i_miso,
	output logic             o_mosi,
	output logic      [7:0]  o_slave_select,
	// Interrupt.
	output logic             o_irq
);

	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		logic [7:0]                                   defsel;
		logic [spi_cs_fmt_pkg::NUM_FMT-1:0][31:0]     fmt;
		logic [15:0]                                  txdata;
		logic [7:0]                                   tsel;
		logic [1:0]                                   fsel;
		logic                                         dreq;
		logic                                         hold;
		logic [1:0]                                   cur_fmt;
		spi_cs_fmt_pkg::state_e                       st;
		logic [4:0]                                   bit_cnt;
		logic [15:0]                                  rxdata;
		logic                                         rx_par;
		logic [6:0]                                   gap_cnt;
		logic                                         held;
		logic [1:0]                                   irq_stat;
		logic [1:0]                                   irq_mask;
		logic [2:0]                                   sclk_sync;
		logic [1:0]                                   miso_sync;
		logic                                         mosi;
		logic [7:0]                                   ss;
		logic                                         dp_valid;
		logic                                         dp_write;
		logic                                         dp_priv;
		logic [7:0]                                   dp_addr;
		logic [31:0]                                  rdata;
	} state_s;

	localparam state_s RESET_S = '{
		defsel:  spi_cs_fmt_pkg::DEF_SEL_RESET,
		ss:      spi_cs_fmt_pkg::DEF_SEL_RESET,
		fmt:     {spi_cs_fmt_pkg::NUM_FMT{spi_cs_fmt_pkg::FMT_RESET}},
		st:      spi_cs_fmt_pkg::ST_IDLE,
		default: '0
	};

	state_s      q;
	state_s      d;
	logic [1:0]  rst_sync_q;
	logic        rst_n;
	logic        wr;
	logic        start;
	logic        sclk_rise;
	logic        sclk_fall;
	logic [31:0] cfmt;
	logic        parity_enable;
	logic        parity_polarity;
	logic        tx_par;
	logic        rx_exp;
	logic [4:0]  last_bit;
	logic [1:0]  w1c;
	logic [1:0]  ev;
	logic [31:0] wmask;
	logic [31:0] rdv;

	// ****************************************************************
	// Reset release.
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************************************
	// Next state.
	// ****************************************************************
	always_comb begin
		d = q;
		start = 1'b0;
		w1c = 2'h0;
		ev = 2'h0;
		wmask = 32'h0000_0000;
		rdv = 32'h0000_0000;
		wr = q.dp_valid & q.dp_write;
		sclk_rise = q.sclk_sync[1] & ~q.sclk_sync[2];
		sclk_fall = ~q.sclk_sync[1] & q.sclk_sync[2];
		cfmt = q.fmt[q.cur_fmt];
		parity_enable = cfmt[spi_cs_fmt_pkg::FMT_PARITY_ENABLE_BIT];
		parity_polarity = cfmt[spi_cs_fmt_pkg::FMT_PARITY_POLARITY_BIT];
		tx_par = (^q.txdata[CHAR_BITS-1:0]) ^ parity_polarity;
		rx_exp = (^q.rxdata[CHAR_BITS-1:0]) ^ parity_polarity;
		last_bit = 5'(CHAR_BITS - 1) + {4'h0, parity_enable};
		d.sclk_sync = {q.sclk_sync[1], q.sclk_sync[0], i_link_clk};
		d.miso_sync = {q.miso_sync[0], i_miso};

		// Register writes in the data phase.
		if (wr) begin
			if (q.dp_addr == spi_cs_fmt_pkg::ADDR_DEFSEL) begin
				d.defsel = i_hwdata[7:0];
			end
			if (q.dp_addr == spi_cs_fmt_pkg::ADDR_TXCTL &&
			    q.st == spi_cs_fmt_pkg::ST_IDLE) begin
				d.txdata = i_hwdata[15:0];
				d.tsel = i_hwdata[spi_cs_fmt_pkg::TX_SEL_LSB +: 8];
				d.fsel = i_hwdata[spi_cs_fmt_pkg::TX_FMT_LSB +: 2];
				d.dreq = i_hwdata[spi_cs_fmt_pkg::TX_DREQ_BIT];
				d.hold = i_hwdata[spi_cs_fmt_pkg::TX_HOLD_BIT];
				start = 1'b1;
			end
			if (q.dp_addr == spi_cs_fmt_pkg::ADDR_IRQ_STAT) begin
				w1c = i_hwdata[1:0];
			end
			if (q.dp_addr == spi_cs_fmt_pkg::ADDR_IRQ_MASK) begin
				d.irq_mask = i_hwdata[1:0];
			end
			wmask = q.dp_priv ? spi_cs_fmt_pkg::FMT_WMASK_PRIV :
			                    spi_cs_fmt_pkg::FMT_WMASK_USER;
			for (int n = 0; n < spi_cs_fmt_pkg::NUM_FMT; n++) begin
				if (q.dp_addr[7:4] == spi_cs_fmt_pkg::ADDR_FMT_PAGE &&
				    q.dp_addr[3:2] == 2'(n)) begin
					d.fmt[n] = (q.fmt[n] & ~wmask) | (i_hwdata & wmask);
				end
			end
		end

		// Transfer engine.
		unique case (q.st)
			spi_cs_fmt_pkg::ST_IDLE: begin
				if (start) begin
					d.st = spi_cs_fmt_pkg::ST_SHIFT;
					d.bit_cnt = 5'h00;
					d.cur_fmt = d.fsel;
					d.rxdata = 16'h0000;
					d.mosi = d.txdata[CHAR_BITS-1];
				end
			end
			spi_cs_fmt_pkg::ST_SHIFT: begin
				if (sclk_rise) begin
					if (int'(q.bit_cnt) < CHAR_BITS) begin
						d.rxdata = {q.rxdata[14:0], q.miso_sync[1]};
					end else begin
						d.rx_par = q.miso_sync[1];
					end
				end
				if (sclk_fall) begin
					if (q.bit_cnt == last_bit) begin
						ev[spi_cs_fmt_pkg::IRQ_DONE_BIT] = 1'b1;
						ev[spi_cs_fmt_pkg::IRQ_PERR_BIT] =
							parity_enable & (q.rx_par != rx_exp);
						d.held = q.hold;
						d.mosi = 1'b0;
						if (q.dreq) begin
							d.st = spi_cs_fmt_pkg::ST_GAP;
							d.gap_cnt = {1'b0, cfmt[spi_cs_fmt_pkg::FMT_INTER_TRANSFER_DELAY_LSB +:
								spi_cs_fmt_pkg::FMT_INTER_TRANSFER_DELAY_W]} +
								spi_cs_fmt_pkg::GAP_EXTRA - 7'h01;
						end else begin
							d.st = spi_cs_fmt_pkg::ST_IDLE;
						end
					end else begin
						d.bit_cnt = q.bit_cnt + 5'h01;
						if (int'(d.bit_cnt) < CHAR_BITS) begin
							d.mosi = q.txdata[CHAR_BITS - 1 - int'(d.bit_cnt)];
						end else begin
							d.mosi = tx_par;
						end
					end
				end
			end
			spi_cs_fmt_pkg::ST_GAP: begin
				if (q.gap_cnt == 7'h00) begin
					d.st = spi_cs_fmt_pkg::ST_IDLE;
				end else begin
					d.gap_cnt = q.gap_cnt - 7'h01;
				end
			end
		endcase

		// Sticky events: a set in the clearing cycle wins.
		d.irq_stat = (q.irq_stat & ~w1c) | ev;

		// Select outputs, registered so unchanged lines never glitch.
		d.ss = (d.st == spi_cs_fmt_pkg::ST_SHIFT || d.held) ?
		       d.tsel : d.defsel;

		// Address phase capture and read data.
		d.dp_valid = i_hsel & i_htrans[1] & i_hready;
		if (d.dp_valid) begin
			d.dp_write = i_hwrite;
			d.dp_priv = i_hprot[1];
			d.dp_addr = i_haddr[7:0];
		end
		case (i_haddr[7:0])
			spi_cs_fmt_pkg::ADDR_DEFSEL:   rdv = {24'h000000, d.defsel};
			spi_cs_fmt_pkg::ADDR_TXCTL:    rdv = {3'h0, d.hold, 1'b0, d.dreq,
				d.fsel, d.tsel, d.txdata};
			spi_cs_fmt_pkg::ADDR_STATUS:   rdv = {30'h0, d.held,
				d.st != spi_cs_fmt_pkg::ST_IDLE};
			spi_cs_fmt_pkg::ADDR_RXDATA:   rdv = {16'h0000, d.rxdata};
			spi_cs_fmt_pkg::ADDR_IRQ_STAT: rdv = {30'h0, d.irq_stat};
			spi_cs_fmt_pkg::ADDR_IRQ_MASK: rdv = {30'h0, d.irq_mask};
			default: begin
				if (i_haddr[7:4] == spi_cs_fmt_pkg::ADDR_FMT_PAGE) begin
					rdv = d.fmt[i_haddr[3:2]];
				end
			end
		endcase
		if (d.dp_valid && !i_hwrite) begin
			d.rdata = rdv;
		end
	end

	// ****************************************************************
	// Registers.
	// ****************************************************************
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RESET_S;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign o_hrdata = q.rdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_mosi = q.mosi;
	assign o_slave_select = q.ss;
	assign o_irq = |(q.irq_stat & q.irq_mask);

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	logic [6:0] gap_len_q;
	logic [6:0] gap_goal_q;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_len_q <= 7'h00;
			gap_goal_q <= 7'h00;
		end else begin
			gap_len_q <= (q.st == spi_cs_fmt_pkg::ST_GAP) ?
			             gap_len_q + 7'h01 : 7'h00;
			if (q.st == spi_cs_fmt_pkg::ST_SHIFT) begin
				gap_goal_q <= {1'b0, cfmt[spi_cs_fmt_pkg::FMT_INTER_TRANSFER_DELAY_LSB +:
					spi_cs_fmt_pkg::FMT_INTER_TRANSFER_DELAY_W]} + spi_cs_fmt_pkg::GAP_EXTRA;
			end
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	sequence s_shift_end;
		q.st == spi_cs_fmt_pkg::ST_SHIFT ##1 q.st != spi_cs_fmt_pkg::ST_SHIFT;
	endsequence
	property p_idle_default;
		(q.st != spi_cs_fmt_pkg::ST_SHIFT && !q.held) |->
			o_slave_select == q.defsel;
	endproperty
	a_idle_default: assert property (p_idle_default)
		else $error("idle selects differ from default pattern");
	property p_busy_pattern;
		q.st == spi_cs_fmt_pkg::ST_SHIFT |-> o_slave_select == q.tsel;
	endproperty
	a_busy_pattern: assert property (p_busy_pattern)
		else $error("selects differ from transfer pattern");
	property p_hold;
		s_shift_end ##0 q.hold |-> q.held && o_slave_select == q.tsel;
	endproperty
	a_hold: assert property (p_hold)
		else $error("held selects released after transfer");
	property p_no_gap;
		s_shift_end ##0 !q.dreq |-> q.st == spi_cs_fmt_pkg::ST_IDLE;
	endproperty
	a_no_gap: assert property (p_no_gap)
		else $error("gap inserted without delay request");
	property p_gap_len;
		(q.st == spi_cs_fmt_pkg::ST_GAP ##1 q.st != spi_cs_fmt_pkg::ST_GAP)
			|-> gap_len_q == gap_goal_q;
	endproperty
	a_gap_len: assert property (p_gap_len)
		else $error("gap length is not delay plus two");
	property p_parity_bit;
		(q.st == spi_cs_fmt_pkg::ST_SHIFT && int'(q.bit_cnt) == CHAR_BITS)
			|-> o_mosi == ((^q.txdata[CHAR_BITS-1:0]) ^ parity_polarity);
	endproperty
	a_parity_bit: assert property (p_parity_bit)
		else $error("wrong parity bit on serial output");
	property p_parity_err;
		(q.st == spi_cs_fmt_pkg::ST_SHIFT && sclk_fall &&
		 q.bit_cnt == last_bit && parity_enable && q.rx_par != rx_exp)
			|=> q.irq_stat[spi_cs_fmt_pkg::IRQ_PERR_BIT];
	endproperty
	a_parity_err: assert property (p_parity_err)
		else $error("parity mismatch not flagged");
	property p_user_parity_polarity;
		(wr && !q.dp_priv && q.dp_addr[7:4] == spi_cs_fmt_pkg::ADDR_FMT_PAGE)
			|=> $stable({q.fmt[3][spi_cs_fmt_pkg::FMT_PARITY_POLARITY_BIT],
				q.fmt[2][spi_cs_fmt_pkg::FMT_PARITY_POLARITY_BIT],
				q.fmt[1][spi_cs_fmt_pkg::FMT_PARITY_POLARITY_BIT],
				q.fmt[0][spi_cs_fmt_pkg::FMT_PARITY_POLARITY_BIT]});
	endproperty
	a_user_parity_polarity: assert property (p_user_parity_polarity)
		else $error("unprivileged write changed parity polarity");
	property p_reserved_zero;
		(d.dp_valid && !i_hwrite) |=> o_hrdata[31:30] == 2'h0 &&
			(q.dp_addr != spi_cs_fmt_pkg::ADDR_DEFSEL || o_hrdata[31:8] == 24'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read nonzero");
	property p_ss_sync;
		!$stable(o_slave_select) |->
			o_slave_select == q.tsel || o_slave_select == q.defsel;
	endproperty
	a_ss_sync: assert property (p_ss_sync)
		else $error("select outputs show a mixed pattern");
endmodule

// *** test/spi_link_partner.sv ***
/*
 * Behavioural serial slave that sits on the far side of the link.
 * Assumes the bench pulses i_start once the transfer has begun.
 */
`timescale 1ns/1ps
module spi_link_partner (
	// Frame control.
	input  wire logic        i_start,
	input  wire logic [4:0]  i_nbits,
	input  wire logic [16:0] i_reply,
	// Serial link.
	input  wire logic        i_mosi,
	output logic             o_link_clk,
	output logic             o_miso,
	// Results.
	output logic      [16:0] o_capture,
	output logic             o_busy
);
	int k;

	initial begin
		o_link_clk = 1'b0;
		o_miso = 1'b0;
		o_capture = 17'h00000;
		o_busy = 1'b0;
	end

	// The link clock runs only inside a frame and rests low.
	always begin
		@(posedge i_start);
		o_busy = 1'b1;
		o_capture = 17'h00000;
		#31;
		for (k = 0; k < i_nbits; k++) begin
			o_miso = i_reply[i_nbits - 1 - k];
			#24 o_link_clk = 1'b1;
			o_capture = {o_capture[15:0], i_mosi};
			#24 o_link_clk = 1'b0;
		end
		o_miso = ~o_miso;
		#30 o_busy = 1'b0;
	end
endmodule

// *** test/spi_chip_select_and_format_tb.sv ***
/*
 * Self-checking bench for the select and format slice.
 * Assumes the design package, the design and the link partner.
 */
`timescale 1ns/1ps
module spi_chip_select_and_format_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [3:0]  hprot = 4'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hready, hresp, lclk, miso, mosi, irq, pbusy;
	logic        start = 1'b0;
	logic [7:0]  ss;
	logic [4:0]  nbits = 5'h08;
	logic [16:0] reply = 17'h0;
	logic [16:0] cap;
	logic [31:0] rd;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          el = 0;

	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	spi_cs_fmt dut_u (
		.i_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hprot(hprot), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_link_clk(lclk), .i_miso(miso), .o_mosi(mosi),
		.o_slave_select(ss), .o_irq(irq)
	);

	spi_link_partner part_u (
		.i_start(start), .i_nbits(nbits), .i_reply(reply),
		.i_mosi(mosi), .o_link_clk(lclk), .o_miso(miso),
		.o_capture(cap), .o_busy(pbusy)
	);

	// ****************************************************************
	// Bus and compare tasks.
	// ****************************************************************
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic timed_out;
		miscompares++;
		tally_and_finish();
	endtask

	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		if (hready !== 1'b1) begin
			timed_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic pr = 1'b1);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		hprot <= {2'h0, pr, 1'b1};
		rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rdy();
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		rdy();
		v = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		rd_reg(a, rd);
		chk(nm, e, rd);
	endtask

	task automatic pchk(input string nm, input logic [31:0] e,
			input logic sel_irq);
		@(negedge clk);
		chk(nm, e, sel_irq ? {31'h0, irq} : {24'h0, ss});
		@(posedge clk);
	endtask

	task automatic xfer(input logic [31:0] ctl, input logic [4:0] nb,
			input logic [16:0] rep);
		int t0;
		int n;
		t0 = 0;
		n = 0;
		wr(spi_cs_fmt_pkg::ADDR_TXCTL, ctl);
		nbits <= nb;
		reply <= rep;
		start <= 1'b1;
		pchk("select_in_transfer", {24'h0, ctl[23:16]}, 1'b0);
		start <= 1'b0;
		do begin
			@(posedge clk);
			n++;
			if (t0 == 0 && ss !== ctl[23:16]) begin
				t0 = cyc;
			end
		end while (pbusy === 1'b1 && n < 400);
		if (pbusy === 1'b1) begin
			timed_out();
		end
		n = 0;
		do begin
			rd_reg(spi_cs_fmt_pkg::ADDR_STATUS, rd);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		if (rd[0] !== 1'b0) begin
			timed_out();
		end
		el = cyc - t0;
	endtask

	// ****************************************************************
	// Tests.
	// ****************************************************************
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		pchk("select_reset", 32'hFF, 1'b0);
		rchk("default_select", 8'h00, 32'hFF);
		rchk("format_0", 8'h20, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rchk("unmapped", 8'h40, 32'h0);
		$display("test reset ended");
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, {24'hFFFFFF, ~(8'h01 << i)});
			pchk("select_idle", {24'h0, ~(8'h01 << i)}, 1'b0);
		end
		rchk("default_select", 8'h00, 32'h7F);
		wr(8'h2C, 32'hFFFFFFFF, 1'b0);
		rchk("format_3", 8'h2C, 32'h3F77_FF1F);
		wr(8'h2C, 32'hFFFFFFFF);
		rchk("format_3", 8'h2C, 32'h3FF7_FF1F);
		wr(8'h2C, 32'h0, 1'b0);
		rchk("format_3", 8'h2C, 32'h0080_0000);
		$display("test registers ended");
		wr(8'h00, 32'h5A);
		wr(8'h20, 32'h3F40_0000);
		wr(8'h24, 32'h3FC0_0000);
		wr(8'h28, 32'h0A00_0000);
		wr(8'h14, 32'h1);
		xfer(32'h04FE_00B5, 5'h09, {8'h0, 8'h3C, 1'b1});
		chk("captured", 32'h16B, {15'h0, cap});
		chk("gap_length", 32'h1, {31'h0, el >= 65 && el <= 66});
		pchk("select_after", 32'h5A, 1'b0);
		rchk("irq_status", 8'h10, 32'h3);
		rchk("receive", 8'h0C, 32'h3C);
		pchk("irq", 32'h1, 1'b1);
		wr(8'h14, 32'h0);
		pchk("irq", 32'h0, 1'b1);
		wr(8'h14, 32'h1);
		pchk("irq", 32'h1, 1'b1);
		wr(8'h10, 32'h3);
		rchk("irq_status", 8'h10, 32'h0);
		pchk("irq", 32'h0, 1'b1);
		$display("test even parity and gap ended");
		xfer(32'h11F7_00B5, 5'h09, {8'h0, 8'h3C, 1'b1});
		chk("captured", 32'h16A, {15'h0, cap});
		pchk("select_held", 32'hF7, 1'b0);
		rchk("status_held", 8'h08, 32'h2);
		rchk("tx_control", 8'h04, 32'h11F7_00B5);
		rchk("irq_status", 8'h10, 32'h1);
		wr(8'h10, 32'h3);
		$display("test odd parity and hold ended");
		xfer(32'h02EF_005A, 5'h08, {9'h0, 8'hC3});
		chk("no_gap", 32'h1, {31'h0, el <= 8});
		chk("captured", 32'h5A, {15'h0, cap});
		pchk("select_after", 32'h5A, 1'b0);
		rchk("receive", 8'h0C, 32'hC3);
		rchk("format_0", 8'h20, 32'h3F40_0000);
		rchk("format_1", 8'h24, 32'h3FC0_0000);
		rchk("format_2", 8'h28, 32'h0A00_0000);
		wr(8'h00, 32'hFF);
		pchk("select_slave", 32'hFF, 1'b0);
		$display("test plain transfer ended");
		tally_and_finish();
	end
endmodule
